// ==== rtl/udgc_top.sv ====
/*
 general and device control registers of a usb full/low-speed controller,
 with dual-role state tracking and an avalon-mm register slave.
 assumes usb-side events (bus reset, resume done, id, vbus, connects) are
 pins from another domain; they are synchronised here.
*/
// Design decision made here: the Avalon-MM register port.
// Functional notes
// R1: two read-only 32-bit words give the controller name in ascii.
// R2: dual-role state reads as 4-bit code; 9 in device-only mode.
// R3: codes 0..8 are the a-device states in documented order.
// R4: codes 9..15 are the b-device states in documented order.
// R5: b-device waits suspended 3 ms before negotiation, only if requested.
// R6: a-device discharge wait holds 100 us before moving on.
// R7: b-device discharge wait holds 100 us before taking host role.
// R8: descriptor base stores table address; low three bits read zero.
// R9: global nak set makes every transaction answer nak.
// R10: low-speed force bit: zero full-speed, one low-speed.
// R11: low-speed bit writable when disabled or frozen; disable keeps it.
// R12: writing one to remote wakeup starts upstream resume; zero ignored.
// R13: remote wakeup clears itself when resume done or bus reset.
// R14: detach set removes pull-up; clear reconnects it.
// R15: writing one to address enable activates the address; zero ignored.
// R16: bus reset clears address enable.
// R17: address field holds bus address; bus reset clears it.
// R18: clock freeze gates usb clock; registers then read-only; the code keeps the enable and freeze bits writable.
// R19: address is bits 6..0, address enable bit 7, written by software.
// R20: reset leaves detach set, so device starts disconnected.
`timescale 1ns/1ps
`include "udgc_map.svh"
module udgc_top #(
   parameter logic [31:0] NAME_ONE      = 32'h75736231, // arbitrary value
   parameter logic [31:0] NAME_TWO      = 32'h63746c30, // arbitrary value
   parameter int          HNP_WAIT_CYC  = `UDGC_HNP_WAIT_CYC,
   parameter int          DISCH_CYC     = `UDGC_DISCHARGE_CYC
) (
   input  wire logic               core_clk,
   input  wire logic               reset,
   input  wire logic [15:0]        avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic [31:0]             avs_readdata,
   output logic                    avs_waitrequest,
   output logic [1:0]              avs_response,
   input  wire logic               usb_bus_reset,
   input  wire logic               resume_done,
   input  wire logic               id_pin,
   input  wire logic               otg_enable,
   input  wire logic               vbus_valid,
   input  wire logic               peer_connect,
   input  wire logic               hnp_request,
   input  wire logic               bus_idle,
   output logic                    global_nak_force,
   output logic                    low_speed_force,
   output logic                    remote_wakeup_request,
   output logic                    pullup_enable,
   output logic                    address_enable,
   output udgc_pkg::udgc_addr_t    device_bus_address,
   output udgc_pkg::udgc_role_t    dual_role_state_code,
   output logic                    usb_clock_gate
);
   import udgc_pkg::*;

   initial begin
      if (HNP_WAIT_CYC < 1 || DISCH_CYC < 1) $error("udgc_top: timing counts must be positive");
   end

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   localparam int NSYNC = 8;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] syn;
   assign raw_in = {bus_idle, hnp_request, peer_connect, vbus_valid,
                    otg_enable, id_pin, resume_done, usb_bus_reset};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         udgc_sync u_sync (
            .core_clk (core_clk),
            .reset    (reset),
            .din      (raw_in[gi]),
            .dout     (syn[gi])
         );
      end
   endgenerate
   wire bus_rst_s  = syn[0];
   wire res_done_s = syn[1];
   wire id_s       = syn[2];
   wire otg_s      = syn[3];
   wire vbus_s     = syn[4];
   wire conn_s     = syn[5];
   wire hnp_req_s  = syn[6];
   wire idle_s     = syn[7];

   // ************************************************************
   // register state
   // ************************************************************
   logic        global_nak_force_ff;
   logic        ls_ff;
   logic        wkup_ff;
   logic        detach_ff;
   logic        address_enable_ff;
   udgc_addr_t  addr_ff;
   logic        enable_ff;
   logic        freeze_ff;
   logic [28:0] desc_ff;
   logic        ack_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  resp_ff;
   udgc_role_t  role_ff;
   udgc_role_t  nxt_role;

   // ************************************************************
   // bus decode
   // ************************************************************
   // one wait cycle: answer registered, waitrequest drops on second edge
   wire        req       = (avs_read | avs_write) & ~ack_ff;
   wire        hit_ctrl  = avs_address == `UDGC_OFS_GEN_CTRL;
   wire        hit_ext   = avs_address == `UDGC_OFS_CTRL_EXT;
   wire        hit_n1    = avs_address == `UDGC_OFS_NAME_ONE;
   wire        hit_n2    = avs_address == `UDGC_OFS_NAME_TWO;
   wire        hit_role  = avs_address == `UDGC_OFS_ROLE_STATE;
   wire        hit_desc  = avs_address == `UDGC_OFS_DESC_BASE;
   wire        hit_any   = hit_ctrl | hit_ext | hit_n1 | hit_n2 | hit_role | hit_desc;
   wire        wr        = req & avs_write;
   wire [31:0] wd        = avs_writedata;
   wire [3:0]  be        = avs_byteenable;
   // R18 frozen registers read-only, except low-speed and the enable and freeze bits
   wire        wr_ok     = ~freeze_ff;
   wire        wr_ctrl   = wr & hit_ctrl;
   wire        wr_ctrl_f = wr_ctrl & wr_ok;
   wire [31:0] ctrl_word = {14'h0000, global_nak_force_ff, 4'h0, ls_ff, 2'b00, wkup_ff, detach_ff, address_enable_ff, addr_ff};
   wire [31:0] role_word = {28'h0000000, role_ff};
   // R8 low bits read zero
   wire [31:0] desc_word = {desc_ff, 3'b000};
   wire [31:0] ext_word  = {30'h00000000, freeze_ff, enable_ff};
   // R1 name words
   wire [31:0] rd_mux    = hit_ctrl ? ctrl_word :
                           hit_ext  ? ext_word  :
                           hit_n1   ? NAME_ONE  :
                           hit_n2   ? NAME_TWO  :
                           hit_role ? role_word :
                           hit_desc ? desc_word : 32'h00000000;
   // R12 write one starts resume
   wire wkup_set  = wr_ctrl_f & be[1] & wd[`UDGC_BIT_REMOTE_WAKEUP_REQUEST];
   // R15 write one activates address
   wire address_enable_set = wr_ctrl_f & be[0] & wd[`UDGC_BIT_ADDRESS_ENABLE];

   // ************************************************************
   // bus answer
   // ************************************************************
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h00000000;
         resp_ff  <= 2'b00;
      end else begin
         ack_ff   <= req;
         rdata_ff <= (req & avs_read) ? rd_mux : 32'h00000000;
         resp_ff  <= (req & ~hit_any) ? 2'b11 : 2'b00;
      end
   end
   assign avs_readdata    = rdata_ff;
   assign avs_response    = resp_ff;
   assign avs_waitrequest = ~ack_ff;

   // ************************************************************
   // control register
   // ************************************************************
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         // R20 reset leaves device detached
         global_nak_force_ff   <= 1'(`UDGC_RST_GEN_CTRL >> `UDGC_BIT_GLOBAL_NAK_FORCE);
         ls_ff     <= 1'b0;
         detach_ff <= 1'b1;
         enable_ff <= 1'b0;
         freeze_ff <= 1'b0;
      end else begin
         if (wr_ctrl_f & be[2]) begin
            global_nak_force_ff <= wd[`UDGC_BIT_GLOBAL_NAK_FORCE];
         end
         // R11 writable even when frozen
         if (wr_ctrl & be[1]) begin
            ls_ff <= wd[`UDGC_BIT_LS];
         end
         // R14 detach drives pull-up
         if (wr_ctrl_f & be[1]) begin
            detach_ff <= wd[`UDGC_BIT_DETACH];
         end
         // enable and freeze always writable
         if (wr & hit_ext & be[0]) begin
            enable_ff <= wd[`UDGC_BIT_ENABLE];
            freeze_ff <= wd[`UDGC_BIT_FREEZE];
         end
      end
   end

   // R13 self-clear on resume done or bus reset; a new write wins
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wkup_ff <= 1'b0;
      end else if (wkup_set) begin
         wkup_ff <= 1'b1;
      end else if (res_done_s | bus_rst_s) begin
         wkup_ff <= 1'b0;
      end
   end

   // R16 R17 bus reset clears address and enable
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         address_enable_ff <= 1'b0;
         addr_ff  <= '0;
      end else if (bus_rst_s) begin
         address_enable_ff <= 1'b0;
         addr_ff  <= '0;
      end else begin
         if (address_enable_set) begin
            address_enable_ff <= 1'b1;
         end
         // R19 address in bits 6..0
         if (wr_ctrl_f & be[0]) begin
            addr_ff <= wd[`UDGC_ADDR_MSB:0];
         end
      end
   end

   // R8 descriptor base, eight-byte aligned
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         desc_ff <= '0;
      end else if (wr & hit_desc & wr_ok) begin
         desc_ff <= wd[31:3];
      end
   end

   // ************************************************************
   // dual-role state machine
   // ************************************************************
   logic hnp_done;
   logic a_disch_done;
   logic b_disch_done;
   wire  hnp_start  = (role_ff != UDGC_B_WAIT_HNP) & (nxt_role == UDGC_B_WAIT_HNP);
   wire  ad_start   = (role_ff != UDGC_A_WAIT_DISCH) & (nxt_role == UDGC_A_WAIT_DISCH);
   wire  bd_start   = (role_ff != UDGC_B_WAIT_DISCH) & (nxt_role == UDGC_B_WAIT_DISCH);

   // R5 3 ms suspend wait
   udgc_timer #(.CYCLES(HNP_WAIT_CYC)) u_hnp (
      .core_clk (core_clk),
      .reset    (reset),
      .start    (hnp_start),
      .abort    (role_ff != UDGC_B_WAIT_HNP && !hnp_start),
      .done     (hnp_done)
   );
   // R6 a-device 100 us discharge
   udgc_timer #(.CYCLES(DISCH_CYC)) u_adis (
      .core_clk (core_clk),
      .reset    (reset),
      .start    (ad_start),
      .abort    (1'b0),
      .done     (a_disch_done)
   );
   // R7 b-device 100 us discharge
   udgc_timer #(.CYCLES(DISCH_CYC)) u_bdis (
      .core_clk (core_clk),
      .reset    (reset),
      .start    (bd_start),
      .abort    (1'b0),
      .done     (b_disch_done)
   );

   // R2 R3 R4 state codes and device-only hold at 9
   always_comb begin
      nxt_role = role_ff;
      if (!otg_s) begin
         nxt_role = UDGC_B_IDLE;
      end else begin
         case (role_ff)
            UDGC_A_IDLE:       if (id_s) nxt_role = UDGC_B_IDLE; else nxt_role = UDGC_A_WAIT_VRISE;
            UDGC_A_WAIT_VRISE: if (vbus_s) nxt_role = UDGC_A_WAIT_BCON;
            UDGC_A_WAIT_BCON:  if (!vbus_s) nxt_role = UDGC_A_VBUS_ERR; else if (conn_s) nxt_role = UDGC_A_HOST;
            UDGC_A_HOST:       if (!vbus_s) nxt_role = UDGC_A_VBUS_ERR; else if (idle_s) nxt_role = UDGC_A_SUSPEND;
            UDGC_A_SUSPEND:    if (!conn_s) nxt_role = UDGC_A_PERIPH; else if (!idle_s) nxt_role = UDGC_A_HOST;
            UDGC_A_PERIPH:     if (idle_s) nxt_role = UDGC_A_WAIT_BCON; else if (id_s) nxt_role = UDGC_A_WAIT_VFALL;
            UDGC_A_WAIT_VFALL: if (!vbus_s) nxt_role = UDGC_A_WAIT_DISCH;
            UDGC_A_VBUS_ERR:   if (id_s) nxt_role = UDGC_A_WAIT_DISCH;
            UDGC_A_WAIT_DISCH: if (a_disch_done) nxt_role = UDGC_A_IDLE;
            UDGC_B_IDLE:       if (!id_s) nxt_role = UDGC_A_IDLE; else if (vbus_s) nxt_role = UDGC_B_PERIPH;
                               else if (hnp_req_s) nxt_role = UDGC_B_SRP_INIT;
            UDGC_B_PERIPH:     if (!vbus_s) nxt_role = UDGC_B_IDLE; else if (idle_s) nxt_role = UDGC_B_WAIT_HNP;
            UDGC_B_WAIT_HNP:   if (!idle_s) nxt_role = UDGC_B_PERIPH;
                               else if (hnp_done && hnp_req_s) nxt_role = UDGC_B_WAIT_DISCH;
            UDGC_B_WAIT_DISCH: if (b_disch_done) nxt_role = UDGC_B_WAIT_ACON;
            UDGC_B_WAIT_ACON:  if (conn_s) nxt_role = UDGC_B_HOST; else if (!vbus_s) nxt_role = UDGC_B_IDLE;
            UDGC_B_HOST:       if (!conn_s || !vbus_s) nxt_role = UDGC_B_IDLE;
            UDGC_B_SRP_INIT:   if (vbus_s) nxt_role = UDGC_B_PERIPH;
            default:           nxt_role = UDGC_B_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         role_ff <= udgc_role_t'(`UDGC_RST_ROLE_STATE);
      end else begin
         role_ff <= nxt_role;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // R9 nak forced while set
   assign global_nak_force      = global_nak_force_ff;
   // R10 speed select
   assign low_speed_force       = ls_ff;
   assign remote_wakeup_request = wkup_ff;
   // R14 pull-up only when attached
   assign pullup_enable         = ~detach_ff;
   assign address_enable        = address_enable_ff;
   assign device_bus_address    = addr_ff;
   assign dual_role_state_code  = role_ff;
   // R18 clock gated while frozen
   assign usb_clock_gate        = freeze_ff;
endmodule

// ==== rtl/udgc_map.svh ====
`ifndef UDGC_MAP_SVH
`define UDGC_MAP_SVH
// ************************************************************
// register byte offsets
// ************************************************************
`define UDGC_OFS_GEN_CTRL      16'h0000
`define UDGC_OFS_CTRL_EXT      16'h0840
`define UDGC_OFS_NAME_ONE      16'h0824
`define UDGC_OFS_NAME_TWO      16'h0828
`define UDGC_OFS_ROLE_STATE    16'h082c
`define UDGC_OFS_DESC_BASE     16'h0830
// ************************************************************
// general control fields
// ************************************************************
`define UDGC_BIT_GLOBAL_NAK_FORCE          17
`define UDGC_BIT_LS            12
`define UDGC_BIT_REMOTE_WAKEUP_REQUEST        9
`define UDGC_BIT_DETACH        8
`define UDGC_BIT_ADDRESS_ENABLE         7
`define UDGC_ADDR_MSB          6
// control extension fields
`define UDGC_BIT_ENABLE        0
`define UDGC_BIT_FREEZE        1
// ************************************************************
// reset values
// ************************************************************
`define UDGC_RST_GEN_CTRL      32'h00000100
`define UDGC_RST_ROLE_STATE    4'h9
`define UDGC_RST_CTRL_EXT      32'h00000000
// ************************************************************
// timing
// ************************************************************
`define UDGC_CLK_MHZ           200
`define UDGC_HNP_WAIT_US       3000
`define UDGC_DISCHARGE_US      100
`define UDGC_HNP_WAIT_CYC      (`UDGC_HNP_WAIT_US * `UDGC_CLK_MHZ)
`define UDGC_DISCHARGE_CYC     (`UDGC_DISCHARGE_US * `UDGC_CLK_MHZ)
`endif

// ==== rtl/udgc_pkg.sv ====
/*
 types shared by the general control block.
 assumes udgc_map.svh supplies offsets and counts.
*/
package udgc_pkg;
   // ************************************************************
   // dual-role state codes
   // ************************************************************
   typedef enum logic [3:0] {
      UDGC_A_IDLE       = 4'b0000,
      UDGC_A_WAIT_VRISE = 4'b0001,
      UDGC_A_WAIT_BCON  = 4'b0010,
      UDGC_A_HOST       = 4'b0011,
      UDGC_A_SUSPEND    = 4'b0100,
      UDGC_A_PERIPH     = 4'b0101,
      UDGC_A_WAIT_VFALL = 4'b0110,
      UDGC_A_VBUS_ERR   = 4'b0111,
      UDGC_A_WAIT_DISCH = 4'b1000,
      UDGC_B_IDLE       = 4'b1001,
      UDGC_B_PERIPH     = 4'b1010,
      UDGC_B_WAIT_HNP   = 4'b1011,
      UDGC_B_WAIT_DISCH = 4'b1100,
      UDGC_B_WAIT_ACON  = 4'b1101,
      UDGC_B_HOST       = 4'b1110,
      UDGC_B_SRP_INIT   = 4'b1111
   } udgc_role_t;
   typedef logic [6:0] udgc_addr_t;
endpackage

// ==== rtl/udgc_sync.sv ====
/*
 two-flop synchroniser for one level.
 assumes din comes from another domain or a pin.
*/
`timescale 1ns/1ps
module udgc_sync (
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic din,
   output logic      dout
);
   logic meta_ff;
   // first stage read only by second stage
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         meta_ff <= 1'b0;
         dout    <= 1'b0;
      end else begin
         meta_ff <= din;
         dout    <= meta_ff;
      end
   end
endmodule

// ==== rtl/udgc_timer.sv ====
/*
 one-shot down counter: start loads CYCLES - 1, done pulses at zero.
 assumes start is a one-cycle pulse on core_clk.
*/
`timescale 1ns/1ps
module udgc_timer #(
   parameter int CYCLES = 20000
) (
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic start,
   input  wire logic abort,
   output logic      done
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt_ff;
   logic         run_ff;
   initial begin
      if (CYCLES < 1) $error("udgc_timer: CYCLES must be at least 1");
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cnt_ff <= '0;
         run_ff <= 1'b0;
         done   <= 1'b0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            run_ff <= 1'b0;
         end else if (start) begin
            cnt_ff <= W'(CYCLES - 1);
            run_ff <= 1'b1;
         end else if (run_ff) begin
            if (cnt_ff == '0) begin
               run_ff <= 1'b0;
               done   <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff - 1'b1;
            end
         end
      end
   end
endmodule

// ==== test/udgc_host_model.sv ====
/*
 usb host seen from the general control block: resume and bus reset.
 assumes the bench commands bus resets and ties the dual-role inputs.
*/
`timescale 1ns/1ps
module udgc_host_model #(
   parameter int RESUME_CYC = 12
) (
   input wire logic core_clk,
   input wire logic remote_wakeup_request,
   input wire logic bus_reset_cmd,
   output logic     usb_bus_reset,
   output logic     resume_done,
   output logic     bus_idle
);
   int cnt = 0;
   initial begin
      usb_bus_reset = 1'b0;
      resume_done = 1'b0;
      bus_idle = 1'b1;
   end
   always @(posedge core_clk) begin
      usb_bus_reset <= bus_reset_cmd;
      // resume signalled, then done reported until it drops
      if (!remote_wakeup_request) begin
         cnt <= 0;
         resume_done <= 1'b0;
         bus_idle <= 1'b1;
      end else if (cnt < RESUME_CYC) begin
         cnt <= cnt + 1;
         bus_idle <= 1'b0;
      end else begin
         resume_done <= 1'b1;
      end
   end
endmodule

// ==== test/udgc_checker.sv ====
/*
 port checks of the general control block.
 assumes binding to udgc_top, udgc_pkg compiled first.
*/
`timescale 1ns/1ps
module udgc_checker #(
   parameter logic [31:0] NAME_TWO = 32'h0
) (
   input wire logic                 core_clk,
   input wire logic                 reset,
   input wire logic [15:0]          avs_address,
   input wire logic                 avs_read,
   input wire logic                 avs_write,
   input wire logic [31:0]          avs_writedata,
   input wire logic [3:0]           avs_byteenable,
   input wire logic [31:0]          avs_readdata,
   input wire logic                 avs_waitrequest,
   input wire logic                 usb_bus_reset,
   input wire logic                 otg_enable,
   input wire logic                 global_nak_force,
   input wire logic                 low_speed_force,
   input wire logic                 remote_wakeup_request,
   input wire logic                 pullup_enable,
   input wire logic                 address_enable,
   input wire udgc_pkg::udgc_addr_t device_bus_address,
   input wire udgc_pkg::udgc_role_t dual_role_state_code,
   input wire logic                 usb_clock_gate
);
   import udgc_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // a write is taken while waitrequest is still high
   wire take = avs_write && avs_waitrequest && avs_address == 16'h0000;
   // frozen control writes are dropped, except the speed bit
   wire w_live = take && !usb_clock_gate;
   wire rd_ok = avs_read && !avs_waitrequest;
   property p_name; rd_ok && avs_address == 16'h0828 |-> avs_readdata == NAME_TWO;
   endproperty
   a_name: assert property (p_name) else $error("name word two wrong");
   property p_desc; rd_ok && avs_address == 16'h0830 |-> avs_readdata[2:0] == 3'h0;
   endproperty
   a_desc: assert property (p_desc) else $error("descriptor base not aligned");
   property p_state; !otg_enable [*4] |-> dual_role_state_code == UDGC_B_IDLE;
   endproperty
   a_state: assert property (p_state) else $error("device-only state not 9");
   property p_nak; w_live && avs_byteenable[2] |=> global_nak_force == $past(avs_writedata[17]);
   endproperty
   a_nak: assert property (p_nak) else $error("global nak not written");
   property p_ls; take && avs_byteenable[1] |=> low_speed_force == $past(avs_writedata[12]);
   endproperty
   a_ls: assert property (p_ls) else $error("low-speed bit not written");
   property p_det; w_live && avs_byteenable[1] |=> pullup_enable == !$past(avs_writedata[8]);
   endproperty
   a_det: assert property (p_det) else $error("pull-up does not follow detach");
   property p_wake; w_live && avs_byteenable[1] && avs_writedata[9] |=> remote_wakeup_request;
   endproperty
   a_wake: assert property (p_wake) else $error("remote wakeup not started");
   property p_aen; w_live && avs_byteenable[0] && !usb_bus_reset && !$past(usb_bus_reset)
      && !$past(usb_bus_reset, 2) |=> device_bus_address == $past(avs_writedata[6:0])
      && address_enable == ($past(address_enable) || $past(avs_writedata[7]));
   endproperty
   a_aen: assert property (p_aen) else $error("address or enable wrong");
   property p_brst; usb_bus_reset [*5] |-> !address_enable && device_bus_address == 7'h00
      && !remote_wakeup_request;
   endproperty
   a_brst: assert property (p_brst) else $error("bus reset left state");
   property p_frz; avs_write && avs_waitrequest && avs_address == 16'h0840 && avs_byteenable[0]
      |=> usb_clock_gate == $past(avs_writedata[1]);
   endproperty
   a_frz: assert property (p_frz) else $error("clock gate not written");
endmodule
bind udgc_top udgc_checker #(.NAME_TWO(NAME_TWO)) i_chk (.core_clk, .reset, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
   .usb_bus_reset, .otg_enable, .global_nak_force, .low_speed_force, .remote_wakeup_request,
   .pullup_enable, .address_enable, .device_bus_address, .dual_role_state_code, .usb_clock_gate);

// ==== test/tb.sv ====
/*
 self-checking bench for the general control block.
 assumes a host model on the usb side.
*/
`timescale 1ns/1ps
module tb;
   import udgc_pkg::*;
   localparam logic [31:0] NAME_TWO = 32'h6e6d3032; // arbitrary value
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic [15:0] avs_address = 16'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'h0;
   logic [31:0] avs_readdata, q;
   logic [1:0]  avs_response, r;
   logic        avs_waitrequest, usb_bus_reset, resume_done, bus_idle;
   logic        bus_reset_cmd = 1'b0, id_pin = 1'b1, otg_enable = 1'b0;
   logic        global_nak_force, low_speed_force, remote_wakeup_request;
   logic        pullup_enable, address_enable, usb_clock_gate;
   udgc_addr_t  device_bus_address;
   udgc_role_t  dual_role_state_code;
   int          mismatches = 0;
   int          compares = 0;
   int          cyc = 0;
   // short timed states keep the run small
   udgc_top #(.NAME_TWO(NAME_TWO), .HNP_WAIT_CYC(20), .DISCH_CYC(10)) i_dut (
      .core_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
      .usb_bus_reset, .resume_done, .id_pin, .otg_enable,
      .vbus_valid(1'b0), .peer_connect(1'b0), .hnp_request(1'b0), .bus_idle,
      .global_nak_force, .low_speed_force, .remote_wakeup_request, .pullup_enable,
      .address_enable, .device_bus_address, .dual_role_state_code, .usb_clock_gate);
   udgc_host_model i_host (.core_clk, .remote_wakeup_request, .bus_reset_cmd,
      .usb_bus_reset, .resume_done, .bus_idle);
   always #2.5 core_clk = ~core_clk;
   task automatic results();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // hang guard, far above the run
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         results();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   // ************************************************************
   // avalon-mm master: hold until waitrequest sampled low
   // ************************************************************
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic [3:0] be);
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      avs_byteenable <= be;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      r = avs_response;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic t_map();
      chk("pullup at reset", pullup_enable, 32'h0);
      xfer(0, 16'h0000, 32'h0, 4'hf);
      chk("ctrl reset", q, 32'h00000100);
      xfer(0, 16'h082c, 32'h0, 4'hf);
      chk("state reg", q, 32'h9);
      xfer(0, 16'h0828, 32'h0, 4'hf);
      chk("name two", q, NAME_TWO);
      xfer(1, 16'h0830, 32'hffffffff, 4'hf);
      xfer(0, 16'h0830, 32'h0, 4'hf);
      chk("desc base", q, 32'hfffffff8);
      xfer(0, 16'h0004, 32'h0, 4'hf);
      chk("unmapped resp", r, 32'h3);
      chk("unmapped data", q, 32'h0);
   endtask
   task automatic t_ctrl();
      xfer(1, 16'h0000, 32'h000210d5, 4'hf);
      chk("nak on", global_nak_force, 32'h1);
      chk("ls on", low_speed_force, 32'h1);
      chk("pullup on", pullup_enable, 32'h1);
      chk("address_enable on", address_enable, 32'h1);
      chk("addr", device_bus_address, 32'h55);
      xfer(0, 16'h0000, 32'h0, 4'hf);
      chk("ctrl read", q, 32'h000210d5);
      xfer(1, 16'h0000, 32'h00000133, 4'hf);
      chk("nak off", global_nak_force, 32'h0);
      chk("ls off", low_speed_force, 32'h0);
      chk("pullup off", pullup_enable, 32'h0);
      chk("address_enable kept", address_enable, 32'h1);
      chk("addr new", device_bus_address, 32'h33);
   endtask
   task automatic t_wake();
      xfer(1, 16'h0000, 32'h00000200, 4'h2);
      chk("wake set", remote_wakeup_request, 32'h1);
      xfer(1, 16'h0000, 32'h0, 4'h2);
      chk("wake zero ignored", remote_wakeup_request, 32'h1);
      for (int i = 0; i < 40 && remote_wakeup_request !== 1'b0; i++) @(posedge core_clk);
      chk("wake self clear", remote_wakeup_request, 32'h0);
   endtask
   task automatic t_busrst();
      xfer(1, 16'h0000, 32'h000002aa, 4'h3);
      @(posedge core_clk);
      bus_reset_cmd <= 1'b1;
      repeat (8) @(posedge core_clk);
      bus_reset_cmd <= 1'b0;
      chk("address_enable cleared", address_enable, 32'h0);
      chk("addr cleared", device_bus_address, 32'h0);
      chk("wake cleared", remote_wakeup_request, 32'h0);
   endtask
   task automatic t_freeze();
      xfer(1, 16'h0840, 32'h00000002, 4'h1);
      chk("gate on", usb_clock_gate, 32'h1);
      xfer(1, 16'h0830, 32'h0, 4'hf);
      xfer(0, 16'h0830, 32'h0, 4'hf);
      chk("desc frozen", q, 32'hfffffff8);
      xfer(1, 16'h0000, 32'h00021000, 4'h6);
      chk("ls frozen write", low_speed_force, 32'h1);
      chk("nak frozen", global_nak_force, 32'h0);
      xfer(1, 16'h0840, 32'h0, 4'h1);
      chk("gate off", usb_clock_gate, 32'h0);
      chk("ls kept disabled", low_speed_force, 32'h1);
   endtask
   task automatic t_role();
      {otg_enable, id_pin} <= 2'b10;
      repeat (6) @(posedge core_clk);
      chk("a-device", dual_role_state_code, 32'h1);
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      t_map();
      t_ctrl();
      t_wake();
      t_busrst();
      t_freeze();
      t_role();
      results();
   end
endmodule
